// file: rtl/fidgp_cyc_eng.sv
// Pin cycle engine: one read, write or protect-program cycle on the flash pins
`timescale 1ns/1ps
module fidgp_cyc_eng (
	input wire logic i_clk,
	input wire logic i_srst,
	fidgp_cyc_if.eng cy,
	input wire logic [fidgp_pkg::FIDGP_DW-1:0] i_dq,
	output logic [fidgp_pkg::FIDGP_DW-1:0] o_dq,
	output logic o_dq_oe,
	output logic [fidgp_pkg::FIDGP_AW-1:0] o_addr,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_hv_addr,
	output logic o_hv_oe
);
	import fidgp_pkg::*;
	// ****************************************
	// State
	// ****************************************
	typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} fidgp_est_t;
	fidgp_est_t st_r, st_nxt;
	logic [FIDGP_CW-1:0] cnt_r, cnt_nxt; // Phase counter
	fidgp_cy_t kind_r, kind_nxt; // Latched kind
	logic [FIDGP_AW-1:0] addr_r, addr_nxt;
	logic [FIDGP_DW-1:0] wd_r, wd_nxt;
	logic [FIDGP_DW-1:0] rd_r, rd_nxt;
	logic hva_r, hva_nxt, hvo_r, hvo_nxt;
	logic [FIDGP_DW-1:0] dq_s1_r, dq_s2_r, dq_s3_r; // Three-stage input sync
	logic [FIDGP_DW-1:0] dq_ok_r, dq_ok_nxt; // Last byte on which stages two and three agreed
	logic done_r, done_nxt;
	// Strobe length for the latched kind
	function automatic logic [FIDGP_CW-1:0] strobe_len(input fidgp_cy_t k);
		strobe_len = (k == FIDGP_CY_PROG) ? FIDGP_CW'(FIDGP_PROG_CYC) : FIDGP_CW'(FIDGP_PHASE_CYC);
	endfunction : strobe_len
	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		kind_nxt = kind_r;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		rd_nxt = rd_r;
		hva_nxt = hva_r;
		hvo_nxt = hvo_r;
		done_nxt = 1'b0;
		// A bus change counts only once the second and third stage agree
		dq_ok_nxt = (dq_s2_r == dq_s3_r) ? dq_s3_r : dq_ok_r;
		case (st_r)
			ST_IDLE: begin
				if (cy.start) begin
					// Address and levels set up before any strobe falls
					kind_nxt = cy.kind;
					addr_nxt = cy.addr;
					wd_nxt = cy.wdata;
					hva_nxt = cy.hv_addr;
					hvo_nxt = cy.hv_oe;
					cnt_nxt = FIDGP_CW'(FIDGP_PHASE_CYC);
					st_nxt = ST_SETUP;
				end
			end
			ST_SETUP: begin
				cnt_nxt = cnt_r - 1'b1;
				if (cnt_r == FIDGP_CW'(1)) begin
					cnt_nxt = strobe_len(kind_r);
					st_nxt = ST_STROBE;
				end
			end
			ST_STROBE: begin
				// Address held stable for the whole strobe
				cnt_nxt = cnt_r - 1'b1;
				if (cnt_r == FIDGP_CW'(1)) begin
					if (kind_r == FIDGP_CY_RD) begin
						// Agreed second and third stage give the read byte
						rd_nxt = dq_ok_r;
					end
					cnt_nxt = FIDGP_CW'(FIDGP_PHASE_CYC);
					st_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				cnt_nxt = cnt_r - 1'b1;
				if (cnt_r == FIDGP_CW'(1)) begin
					hva_nxt = 1'b0;
					hvo_nxt = 1'b0;
					done_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end
	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r <= ST_IDLE;
			cnt_r <= '0;
			kind_r <= FIDGP_CY_RD;
			addr_r <= '0;
			wd_r <= '0;
			rd_r <= '0;
			hva_r <= 1'b0;
			hvo_r <= 1'b0;
			done_r <= 1'b0;
			dq_s1_r <= '0;
			dq_s2_r <= '0;
			dq_s3_r <= '0;
			dq_ok_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			kind_r <= kind_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
			hva_r <= hva_nxt;
			hvo_r <= hvo_nxt;
			done_r <= done_nxt;
			dq_s1_r <= i_dq;
			dq_s2_r <= dq_s1_r;
			dq_s3_r <= dq_s2_r;
			dq_ok_r <= dq_ok_nxt;
		end
	end
	// ****************************************
	// Pin drive
	// ****************************************
	wire busy = (st_r != ST_IDLE);
	wire strobe = (st_r == ST_STROBE);
	wire is_rd = (kind_r == FIDGP_CY_RD);
	assign o_addr = addr_r;
	assign o_ce_n = ~busy;
	// Write: strobe low with chip select low, output enable high
	assign o_we_n = ~(strobe && !is_rd);
	assign o_oe_n = ~(strobe && is_rd);
	// Data driven through setup, strobe and hold so the device latches at the rise
	assign o_dq = wd_r;
	assign o_dq_oe = busy && (kind_r == FIDGP_CY_WR);
	assign o_hv_addr = hva_r;
	assign o_hv_oe = hvo_r;
	assign cy.done = done_r;
	assign cy.rdata = rd_r;
endmodule : fidgp_cyc_eng

// file: rtl/fidgp_cyc_if.sv
// Interface between the sequencer and the pin cycle engine
`timescale 1ns/1ps
interface fidgp_cyc_if;
	import fidgp_pkg::*;
	logic start; // Start one bus cycle
	fidgp_cy_t kind; // Cycle kind
	logic [FIDGP_AW-1:0] addr; // Address to drive
	logic [FIDGP_DW-1:0] wdata; // Data to write
	logic hv_addr; // High voltage on the address pin
	logic hv_oe; // High voltage on output enable
	logic done; // Cycle finished pulse
	logic [FIDGP_DW-1:0] rdata; // Sampled read data
	modport seq (output start, kind, addr, wdata, hv_addr, hv_oe, input done, rdata);
	modport eng (input start, kind, addr, wdata, hv_addr, hv_oe, output done, rdata);
endinterface : fidgp_cyc_if

// file: rtl/fidgp_host.sv
// Host controller that identifies a flash device and programs and checks group protection
// Overview of operation
// - High-voltage detect on address pin selects identification
// - Host keeps address bit one low for ids
// - Write: strobe low, select low, output-enable high
// - Protect needs high voltage on address and enable
// - Group address stable through the whole strobe
// - Unlock writes AAh, 55h, then 90h
`timescale 1ns/1ps
module fidgp_host (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire fidgp_pkg::fidgp_op_t i_req_op,
	input wire logic [fidgp_pkg::FIDGP_AW-1:0] i_req_addr,
	output logic o_rsp_valid,
	output logic [fidgp_pkg::FIDGP_DW-1:0] o_rsp_data,
	output logic o_rsp_parity_ok,
	output logic o_rsp_protected,
	output logic [7:0] o_prot_map,
	input wire logic [fidgp_pkg::FIDGP_DW-1:0] i_dq,
	output logic [fidgp_pkg::FIDGP_DW-1:0] o_dq,
	output logic o_dq_oe,
	output logic [fidgp_pkg::FIDGP_AW-1:0] o_addr,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_hv_addr,
	output logic o_hv_oe
);
	import fidgp_pkg::*;
	// ****************************************
	// Declarations
	// ****************************************
	typedef enum {ST_IDLE, ST_CYC, ST_WAIT, ST_RSP} fidgp_st_t;
	fidgp_st_t st_r, st_nxt;
	fidgp_op_t op_r, op_nxt; // Operation in progress
	logic [FIDGP_AW-1:0] ad_r, ad_nxt; // Request address
	logic [1:0] step_r, step_nxt; // Cycle index in a sequence
	logic [FIDGP_DW-1:0] rsp_r, rsp_nxt; // Response byte
	logic par_r, par_nxt; // Response parity good
	logic prt_r, prt_nxt; // Response protect flag
	logic [7:0] map_r, map_nxt; // Known group protection, one bit per group
	logic rv_r, rv_nxt; // Response valid pulse
	fidgp_cyc_if cyc ();
	// Group index from address bits 20..18
	function automatic logic [2:0] sector_group_index(input logic [FIDGP_AW-1:0] a);
		sector_group_index = a[FIDGP_AW-1:FIDGP_GRP_LSB];
	endfunction : sector_group_index
	// Id read address: bit 0 kept, bits 1, 2 and 6 low, group bits kept
	function automatic logic [FIDGP_AW-1:0] id_addr(input logic [FIDGP_AW-1:0] a);
		id_addr = (a & ~21'h000047) | {20'h00000, a[0]};
	endfunction : id_addr
	// Protect read address: group bits with bits 6,1,0 = 0,1,0
	function automatic logic [FIDGP_AW-1:0] prot_addr(input logic [FIDGP_AW-1:0] a);
		prot_addr = {sector_group_index(a), 18'h00000} | FIDGP_ADR_PROT;
	endfunction : prot_addr
	// ****************************************
	// Sequence table: one cycle of each operation step
	// ****************************************
	logic last_step; // Current step ends the operation
	always_comb begin
		cyc.kind = FIDGP_CY_RD;
		cyc.addr = '0;
		cyc.wdata = '0;
		cyc.hv_addr = 1'b0;
		cyc.hv_oe = 1'b0;
		last_step = 1'b1;
		case (op_r)
			FIDGP_OP_HV_ID: begin
				cyc.hv_addr = 1'b1;
				cyc.addr = id_addr(ad_r);
			end
			FIDGP_OP_CMD_ID: begin
				cyc.kind = FIDGP_CY_WR;
				last_step = (step_r == 2'd2);
				// Three writes, each latched by the device as address and data
				case (step_r)
					2'd0: begin
						cyc.addr = FIDGP_ADR_U1;
						cyc.wdata = FIDGP_DAT_U1;
					end
					2'd1: begin
						cyc.addr = FIDGP_ADR_U2;
						cyc.wdata = FIDGP_DAT_U2;
					end
					default: begin
						cyc.addr = FIDGP_ADR_U1;
						cyc.wdata = FIDGP_DAT_ID;
					end
				endcase
			end
			FIDGP_OP_READ: begin
				// After the id command offset 02h reports protection
				cyc.addr = ad_r;
			end
			FIDGP_OP_PROTECT: begin
				cyc.kind = FIDGP_CY_PROG;
				cyc.hv_addr = 1'b1;
				cyc.hv_oe = 1'b1;
				cyc.addr = prot_addr(ad_r);
			end
			FIDGP_OP_VERIFY: begin
				cyc.hv_addr = 1'b1;
				cyc.addr = prot_addr(ad_r);
			end
			FIDGP_OP_EXIT: begin
				cyc.kind = FIDGP_CY_WR;
				cyc.wdata = FIDGP_DAT_RST;
			end
			default: ;
		endcase
	end
	// ****************************************
	// Sequencer next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		op_nxt = op_r;
		ad_nxt = ad_r;
		step_nxt = step_r;
		rsp_nxt = rsp_r;
		par_nxt = par_r;
		prt_nxt = prt_r;
		map_nxt = map_r;
		rv_nxt = 1'b0;
		cyc.start = 1'b0;
		case (st_r)
			ST_IDLE: begin
				if (i_req_valid) begin
					op_nxt = i_req_op;
					ad_nxt = i_req_addr;
					step_nxt = 2'd0;
					st_nxt = ST_CYC;
				end
			end
			ST_CYC: begin
				cyc.start = 1'b1;
				st_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (cyc.done) begin
					if (last_step) begin
						rsp_nxt = cyc.rdata;
						// Odd parity across the whole byte
						par_nxt = ^cyc.rdata;
						prt_nxt = cyc.rdata[0];
						// Verify result updates the group map
						if (op_r == FIDGP_OP_VERIFY) begin
							map_nxt[sector_group_index(ad_r)] = cyc.rdata[0];
						end
						st_nxt = ST_RSP;
					end else begin
						step_nxt = step_r + 2'd1;
						st_nxt = ST_CYC;
					end
				end
			end
			ST_RSP: begin
				rv_nxt = 1'b1;
				st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end
	// ****************************************
	// Sequencer registers
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r <= ST_IDLE;
			op_r <= FIDGP_OP_READ;
			ad_r <= '0;
			step_r <= 2'd0;
			rsp_r <= '0;
			par_r <= 1'b0;
			prt_r <= 1'b0;
			map_r <= 8'h00;
			rv_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			ad_r <= ad_nxt;
			step_r <= step_nxt;
			rsp_r <= rsp_nxt;
			par_r <= par_nxt;
			prt_r <= prt_nxt;
			map_r <= map_nxt;
			rv_r <= rv_nxt;
		end
	end
	// ****************************************
	// Outputs and pin engine
	// ****************************************
	assign o_req_ready = (st_r == ST_IDLE);
	assign o_rsp_valid = rv_r;
	assign o_rsp_data = rsp_r;
	assign o_rsp_parity_ok = par_r;
	assign o_rsp_protected = prt_r;
	assign o_prot_map = map_r;
	// Strobes set up and released in separate phases, so address settles first
	fidgp_cyc_eng u_eng (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.cy(cyc.eng),
		.i_dq(i_dq),
		.o_dq(o_dq),
		.o_dq_oe(o_dq_oe),
		.o_addr(o_addr),
		.o_ce_n(o_ce_n),
		.o_oe_n(o_oe_n),
		.o_we_n(o_we_n),
		.o_hv_addr(o_hv_addr),
		.o_hv_oe(o_hv_oe)
	);
endmodule : fidgp_host

// file: rtl/fidgp_pkg.sv
// Package of constants and types for the flash identification and group-protect host controller
package fidgp_pkg;
	// ****************************************
	// Bus widths
	// ****************************************
	localparam int FIDGP_AW = 21; // Flash address width
	localparam int FIDGP_DW = 8; // Flash data width
	// ****************************************
	// Address fields
	// ****************************************
	localparam int FIDGP_GRP_LSB = 18; // Sector group index low bit
	localparam int FIDGP_SEC_LSB = 16; // Sector index low bit
	localparam logic [FIDGP_AW-1:0] FIDGP_ADR_MFR = 21'h000000; // Manufacturer byte
	localparam logic [FIDGP_AW-1:0] FIDGP_ADR_DEV = 21'h000001; // Device byte
	localparam logic [FIDGP_AW-1:0] FIDGP_ADR_PROT = 21'h000002; // Protect status, bits 6,1,0
	localparam logic [FIDGP_AW-1:0] FIDGP_ADR_U1 = 21'h000555; // Unlock address one
	localparam logic [FIDGP_AW-1:0] FIDGP_ADR_U2 = 21'h0002aa; // Unlock address two
	localparam logic [FIDGP_DW-1:0] FIDGP_DAT_U1 = 8'haa; // Unlock data one
	localparam logic [FIDGP_DW-1:0] FIDGP_DAT_U2 = 8'h55; // Unlock data two
	localparam logic [FIDGP_DW-1:0] FIDGP_DAT_ID = 8'h90; // Identification command
	localparam logic [FIDGP_DW-1:0] FIDGP_DAT_RST = 8'hf0; // Return to read mode
	// ****************************************
	// Timing, 100 MHz clock
	// ****************************************
	localparam int FIDGP_CLK_NS = 10; // Clock period in ns
	localparam int FIDGP_PHASE_NS = 100; // Least setup, strobe and hold phase
	localparam int FIDGP_PHASE_CYC = (FIDGP_PHASE_NS + FIDGP_CLK_NS - 1) / FIDGP_CLK_NS;
	localparam int FIDGP_PROG_US = 100; // Least protect programming pulse
	localparam int FIDGP_PROG_CYC = (FIDGP_PROG_US * 1000 + FIDGP_CLK_NS - 1) / FIDGP_CLK_NS;
	localparam int FIDGP_CW = 14; // Counter width, holds FIDGP_PROG_CYC
	// ****************************************
	// Operation codes on the request port
	// ****************************************
	typedef enum logic [2:0] {
		FIDGP_OP_HV_ID, // Read id byte with high voltage identification level
		FIDGP_OP_CMD_ID, // Unlock and identification command sequence
		FIDGP_OP_READ, // Plain read at the given address
		FIDGP_OP_PROTECT, // Program protection of one sector group
		FIDGP_OP_VERIFY, // High-voltage verify of one sector group
		FIDGP_OP_EXIT // Write read/reset command
	} fidgp_op_t;
	// ****************************************
	// Bus cycle kinds for the cycle engine
	// ****************************************
	typedef enum logic [1:0] {
		FIDGP_CY_RD,
		FIDGP_CY_WR,
		FIDGP_CY_PROG
	} fidgp_cy_t;
endpackage : fidgp_pkg

// file: verif/fidgp_dev_model.sv
// Behavioural flash device: identification, command latch, group protection
`timescale 1ns/1ps
module fidgp_dev_model #(
	parameter logic [7:0] MFR_CODE = 8'h1a, // Arbitrary value, odd parity
	parameter logic [7:0] DEV_CODE = 8'h7f // Arbitrary value, odd parity
) (
	input wire logic [fidgp_pkg::FIDGP_AW-1:0] i_addr,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_hv_addr,
	input wire logic i_hv_oe,
	input wire logic [fidgp_pkg::FIDGP_DW-1:0] i_dq,
	output logic [fidgp_pkg::FIDGP_DW-1:0] o_dq
);
	import fidgp_pkg::*;
	logic [7:0] prot = 8'h00;
	logic id_mode = 1'b0; // Id bytes readable by command
	logic [1:0] step = 2'h0; // Unlock progress
	logic [20:0] lat_a = 21'h000000; // Latched address, known so a reset edge cannot spoil unlock
	logic [7:0] id_q; // Identification byte
	logic [7:0] rd_q; // Byte offered on a read
	logic [7:0] last_q = 8'h00; // Last byte driven
	wire wr_n = i_we_n | i_ce_n; // Later fall, earlier rise of both strobes
	wire drv = !i_ce_n && !i_oe_n && i_we_n; // Read drives the bus
	wire hit1 = lat_a[10:0] == FIDGP_ADR_U1[10:0];
	wire hit2 = lat_a[10:0] == FIDGP_ADR_U2[10:0];
	// Address capture
	always @(negedge wr_n) if (i_oe_n || i_hv_oe) lat_a = i_addr;
	// Data capture: protect pulse or command
	always @(posedge wr_n) begin
		if (i_hv_addr && i_hv_oe) begin
			// Group must not move under the pulse
			if (i_addr[20:18] == lat_a[20:18]) prot[lat_a[20:18]] = 1'b1;
		end else if (i_oe_n) begin
			case (step)
				2'h0: step = (hit1 && i_dq == FIDGP_DAT_U1) ? 2'h1 : 2'h0;
				2'h1: step = (hit2 && i_dq == FIDGP_DAT_U2) ? 2'h2 : 2'h0;
				default: begin
					id_mode = id_mode | (hit1 && i_dq == FIDGP_DAT_ID);
					step = 2'h0;
				end
			endcase
			if (i_dq == FIDGP_DAT_RST) id_mode = 1'b0;
		end
	end
	// Identification byte from bits 6, 1, 0; protect byte also from group bits 20..18
	always_comb begin
		case ({i_addr[6], i_addr[1], i_addr[0]})
			3'h0: id_q = MFR_CODE;
			3'h1: id_q = DEV_CODE;
			3'h2: id_q = {7'h00, prot[i_addr[20:18]]};
			default: id_q = 8'h00;
		endcase
	end
	// Array bytes depend on the sector index
	assign rd_q = (i_hv_addr || id_mode) ? id_q : i_addr[7:0] ^ {3'h0, i_addr[20:16]} ^ 8'h5a;
	// Released bus shows the inverse of the last byte
	assign o_dq = drv ? rd_q : ~last_q;
	always @(negedge drv) last_q = rd_q;
endmodule : fidgp_dev_model

// file: verif/fidgp_host_properties.sv
// Checker of the host controller flash pins and responses
`timescale 1ns/1ps
module fidgp_host_properties (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic o_rsp_valid,
	input wire logic [fidgp_pkg::FIDGP_DW-1:0] o_rsp_data,
	input wire logic o_rsp_parity_ok,
	input wire logic o_rsp_protected,
	input wire logic [fidgp_pkg::FIDGP_AW-1:0] o_addr,
	input wire logic o_ce_n,
	input wire logic o_oe_n,
	input wire logic o_we_n,
	input wire logic o_dq_oe,
	input wire logic o_hv_addr,
	input wire logic o_hv_oe
);
	import fidgp_pkg::*;
	// ****************************************
	// Strobe width counter
	// ****************************************
	logic [15:0] low_r; // Cycles of write strobe low
	logic [15:0] low_nxt; // Next count
	// Counts while the strobe is low, clears when it is high
	always_comb low_nxt = (i_srst || o_we_n) ? 16'h0000 : low_r + 16'h0001;
	// Registers the count
	always_ff @(posedge i_clk) low_r <= low_nxt;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	a_write_qual: assert property (!o_we_n |-> !o_ce_n && (o_oe_n || o_hv_oe))
		else $error("write strobe without select or with output enable");
	a_no_clash: assert property (!o_oe_n |-> !o_dq_oe)
		else $error("data driven during read");
	a_data_drive: assert property (!o_we_n && !o_hv_oe |-> o_dq_oe)
		else $error("write data not driven");
	a_hv_pair: assert property (o_hv_oe |-> o_hv_addr)
		else $error("enable high voltage without address high voltage");
	a_prog_pulse: assert property ($rose(o_we_n) && o_hv_oe |-> low_r >= 16'(FIDGP_PROG_CYC))
		else $error("protect pulse too short");
	a_cmd_pulse: assert property ($rose(o_we_n) && !o_hv_oe |-> low_r == 16'(FIDGP_PHASE_CYC))
		else $error("command strobe width wrong");
	a_addr_hold: assert property (!o_we_n && !$past(o_we_n) |-> $stable(o_addr))
		else $error("address moved under write strobe");
	a_hv_steady: assert property (!o_ce_n && !$past(o_ce_n) |-> $stable(o_hv_addr))
		else $error("high voltage changed while selected");
	a_id_addr: assert property (!o_oe_n && o_hv_addr |-> !o_addr[6] && !(o_addr[1] && o_addr[0]))
		else $error("identification read address bits wrong");
	a_flag_parity: assert property (o_rsp_valid |-> o_rsp_parity_ok == ^o_rsp_data)
		else $error("parity flag wrong");
	a_flag_prot: assert property (o_rsp_valid |-> o_rsp_protected == o_rsp_data[0])
		else $error("protect flag wrong");
endmodule : fidgp_host_properties

// file: verif/fidgp_host_tb.sv
// Self-checking bench of the host controller against the device model
`timescale 1ns/1ps
module fidgp_host_tb;
	import fidgp_pkg::*;
	localparam logic [7:0] MFR = 8'h1a; // Arbitrary value, odd parity
	localparam logic [7:0] DEV = 8'h7f; // Arbitrary value, odd parity
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic req_valid = 1'b0;
	fidgp_op_t req_op = FIDGP_OP_READ;
	logic [FIDGP_AW-1:0] req_addr = 21'h000000;
	logic ready, rsp_valid, par_ok, prot_hit, dq_oe, ce_n, oe_n, we_n, hv_a, hv_oe;
	logic [7:0] rsp_data, map, h_dq, d_dq;
	logic [FIDGP_AW-1:0] addr;
	wire [7:0] dq = dq_oe ? h_dq : d_dq; // Bus level from both drivers
	int failures = 0;
	int checked = 0;
	initial forever #5 clk = ~clk;
	fidgp_host DUT (.i_clk(clk), .i_srst(srst), .i_req_valid(req_valid), .o_req_ready(ready),
		.i_req_op(req_op), .i_req_addr(req_addr), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
		.o_rsp_parity_ok(par_ok), .o_rsp_protected(prot_hit), .o_prot_map(map), .i_dq(dq),
		.o_dq(h_dq), .o_dq_oe(dq_oe), .o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
		.o_hv_addr(hv_a), .o_hv_oe(hv_oe));
	fidgp_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.i_addr(addr), .i_ce_n(ce_n),
		.i_oe_n(oe_n), .i_we_n(we_n), .i_hv_addr(hv_a), .i_hv_oe(hv_oe), .i_dq(dq), .o_dq(d_dq));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : tally_and_finish
	// One request, bounded wait for the response
	task automatic req(input fidgp_op_t op, input logic [FIDGP_AW-1:0] a);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		req_op = op;
		req_addr = a;
		req_valid = 1'b1;
		// Ready comes from state only, so the value seen now stands at the next edge
		while (ready !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		// A ready that never came is reported as a timeout below
		if (ready !== 1'b1) n = 20000;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		// Response looked at off the edge, while it stands
		while (rsp_valid !== 1'b1 && n < 20000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (rsp_valid !== 1'b1) begin
			failures++;
			$display("unexpected response: expected 1, seen timeout");
			tally_and_finish();
		end
	endtask : req
	task automatic rd(input fidgp_op_t op, input logic [FIDGP_AW-1:0] a, input logic [7:0] e);
		req(op, a);
		chk("data", rsp_data, e);
	endtask : rd
	task automatic t_reset();
		chk("map", map, 8'h00);
		chk("pins", {ready, ce_n, oe_n, we_n, dq_oe, hv_a, hv_oe}, 7'h78);
		$display("test reset done");
	endtask : t_reset
	task automatic t_hv_id();
		rd(FIDGP_OP_HV_ID, 21'h1fff80, MFR);
		chk("parity", par_ok, 1'b1);
		rd(FIDGP_OP_HV_ID, 21'h1fffff, DEV);
		chk("parity", par_ok, 1'b1);
		$display("test hv_id done");
	endtask : t_hv_id
	task automatic t_cmd();
		req(FIDGP_OP_CMD_ID, 21'h000000);
		rd(FIDGP_OP_READ, 21'h1ff800, MFR);
		rd(FIDGP_OP_READ, 21'h0ab001, DEV);
		rd(FIDGP_OP_READ, 21'h140002, 8'h00);
		req(FIDGP_OP_EXIT, 21'h000000);
		rd(FIDGP_OP_READ, 21'h1f0000, 8'h45);
		$display("test cmd done");
	endtask : t_cmd
	task automatic t_protect();
		logic [7:0] em;
		em = 8'ha1;
		for (int g = 0; g < 8; g++) begin
			if (em[g]) req(FIDGP_OP_PROTECT, {g[2:0], 18'h00000});
		end
		for (int g = 0; g < 8; g++) begin
			rd(FIDGP_OP_VERIFY, {g[2:0], 18'h3ffff}, {7'h00, em[g]});
			chk("flag", prot_hit, em[g]);
		end
		chk("map", map, em);
		req(FIDGP_OP_CMD_ID, 21'h000000);
		rd(FIDGP_OP_READ, 21'h140002, 8'h01);
		rd(FIDGP_OP_READ, 21'h0c0002, 8'h00);
		req(FIDGP_OP_EXIT, 21'h000000);
		$display("test protect done");
	endtask : t_protect
	// Reset in mid-run clears the group map and releases every pin
	task automatic t_mid_reset();
		@(posedge clk);
		#1;
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		srst = 1'b0;
		chk("map", map, 8'h00);
		chk("pins", {ready, ce_n, oe_n, we_n, dq_oe, hv_a, hv_oe}, 7'h78);
		rd(FIDGP_OP_HV_ID, 21'h000000, MFR);
		$display("test mid_reset done");
	endtask : t_mid_reset
	initial begin
		repeat (2) @(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		t_hv_id();
		t_cmd();
		t_protect();
		t_mid_reset();
		tally_and_finish();
	end
endmodule : fidgp_host_tb
bind fidgp_host fidgp_host_properties props (.i_clk(i_clk), .i_srst(i_srst),
	.o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_rsp_parity_ok(o_rsp_parity_ok),
	.o_rsp_protected(o_rsp_protected), .o_addr(o_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
	.o_we_n(o_we_n), .o_dq_oe(o_dq_oe), .o_hv_addr(o_hv_addr), .o_hv_oe(o_hv_oe));
